// file: ptstc_pkg.sv
/*
 * Package for the trigger and timestamp control block: register offsets,
 * field positions, reset values and the carrier types of the register port.
 * Assumes a single 50 MHz core clock and a plain strobe-based register port.
 */
package ptstc_pkg;
    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 32;
    localparam int          NUM_TRIG      = 3;
    localparam int          NUM_TS        = 2;
    localparam int          NS_W          = 30;
    localparam int          CNT_W         = 4;

    localparam logic [11:0] OFS_CTRL      = 12'h52C;
    localparam logic [11:0] OFS_TGT_NS    = 12'h530;
    localparam logic [11:0] OFS_TGT_S     = 12'h534;
    localparam logic [11:0] OFS_INDEX     = 12'h540;
    localparam logic [11:0] OFS_TRIG_CFG  = 12'h544;
    localparam logic [11:0] OFS_INT_STAT  = 12'h548;
    localparam logic [11:0] OFS_INT_CLR   = 12'h54C;
    localparam logic [11:0] OFS_INT_EN    = 12'h550;

    localparam int          B_OUT_SEL     = 8;
    localparam int          B_PIN_IN      = 7;
    localparam int          B_DIR         = 6;
    localparam int          B_TS_INT_EN   = 5;
    localparam int          B_TRIG_ACT    = 4;
    localparam int          B_TRIG_EN     = 3;
    localparam int          B_TRIG_RST    = 2;
    localparam int          B_TS_EN       = 1;
    localparam int          B_TS_RST      = 0;
    localparam int          B_TS_IDX      = 8;
    localparam int          B_NOW         = 0;
    localparam int          B_NOTIFY      = 1;
    localparam int          B_LEVEL       = 2;
    localparam int          I_DONE0       = 0;
    localparam int          I_ERR0        = 3;
    localparam int          I_TS0         = 6;
    localparam int          NUM_IRQ       = 8;

    localparam logic [31:0] ZERO32        = 32'h0000_0000;
    localparam logic [1:0]  TRIG_IDX_MAX  = 2'h2;
    localparam logic [3:0]  CNT_MAX       = 4'hF;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ptstc_req_type;

    typedef struct packed {
        logic [31:0]     sec;
        logic [NS_W-1:0] ns;
    } ptstc_time_type;

    typedef enum logic [1:0] {
        TRIG_IDLE,
        TRIG_WAIT,
        TRIG_DONE
    } ptstc_trig_state_type;
endpackage

// file: ptstc_top.sv
/*
 * Trigger output and timestamp input control for one general-purpose pin.
 * Assumes the system time arrives on the core clock and the pin input is
 * asynchronous. Registers are reached over a plain strobe port.
 */
// Implementation choice: the address-and-strobe port.
module ptstc_top
    import ptstc_pkg::*;
(
    // Clock and reset.
    input  wire logic                  CORE_CLK_I,
    input  wire logic                  NRST_I,
    // Register port.
    input  wire ptstc_req_type         REQ_I,
    output logic [DATA_W-1:0]          RDATA_O,
    // Synchronised system time.
    input  wire ptstc_time_type        SYS_TIME_I,
    // General-purpose pin.
    input  wire logic                  PIN_I,
    output logic                       PIN_O,
    output logic                       PIN_OE_O,
    // Interrupt.
    output logic                       IRQ_O
);
    function automatic logic time_reached(input ptstc_time_type now,
                                          input logic [31:0] s,
                                          input logic [NS_W-1:0] ns);
        time_reached = (now.sec > s) || ((now.sec == s) && (now.ns >= ns));
    endfunction

    // Pin input synchroniser; the second stage is read, and pin_prev behind it is read for the rising-edge detect.
    logic pin_s1, pin_s2, pin_prev;
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pin_s1   <= 1'b0;
            pin_s2   <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            pin_s1   <= PIN_I;
            pin_s2   <= pin_s1;
            pin_prev <= pin_s2;
        end
    end
    wire logic pin_rise = pin_s2 & ~pin_prev;

    // Register and unit state.
    logic [1:0]             trig_idx, next_trig_idx;
    logic                   ts_idx, next_ts_idx;
    logic                   out_sel, next_out_sel;
    logic                   dir, next_dir;
    logic [NUM_TS-1:0]      ts_int_en, next_ts_int_en;
    logic [NUM_TS-1:0]      ts_en, next_ts_en;
    logic [NUM_TS-1:0]      ts_rst, next_ts_rst;
    logic [NUM_TS-1:0]      capture_ready_flag, next_capture_ready_flag;
    logic [NUM_TS-1:0]      ts_ovf, next_ts_ovf;
    logic [CNT_W-1:0]       ts_cnt [NUM_TS];
    logic [CNT_W-1:0]       next_ts_cnt [NUM_TS];
    logic [NUM_TRIG-1:0]    tr_en, next_tr_en;
    logic [NUM_TRIG-1:0]    tr_rst, next_tr_rst;
    logic [NUM_TRIG-1:0]    tr_err, next_tr_err;
    logic [NUM_TRIG-1:0]    tr_lvl, next_tr_lvl;
    logic [2:0]             tr_cfg [NUM_TRIG];
    logic [2:0]             next_tr_cfg [NUM_TRIG];
    logic [NS_W-1:0]        tgt_ns [NUM_TRIG];
    logic [NS_W-1:0]        next_tgt_ns [NUM_TRIG];
    logic [31:0]            tgt_s [NUM_TRIG];
    logic [31:0]            next_tgt_s [NUM_TRIG];
    logic [NUM_IRQ-1:0]     int_stat, next_int_stat;
    logic [NUM_IRQ-1:0]     int_en, next_int_en;
    logic [DATA_W-1:0]      next_rdata;
    logic [NUM_TRIG-1:0]    fire;
    logic [NUM_TRIG-1:0]    late;
    logic                   comb_out;

    wire logic wr_ctrl = REQ_I.wr && (REQ_I.addr == OFS_CTRL);

    always_comb begin
        next_trig_idx  = trig_idx;
        next_ts_idx    = ts_idx;
        next_out_sel   = out_sel;
        next_dir       = dir;
        next_ts_int_en = ts_int_en;
        next_ts_en     = ts_en;
        next_ts_rst    = ts_rst;
        next_capture_ready_flag    = capture_ready_flag;
        next_ts_ovf    = ts_ovf;
        next_ts_cnt    = ts_cnt;
        next_tr_en     = tr_en;
        next_tr_rst    = tr_rst;
        next_tr_err    = tr_err;
        next_tr_lvl    = tr_lvl;
        next_tr_cfg    = tr_cfg;
        next_tgt_ns    = tgt_ns;
        next_tgt_s     = tgt_s;
        next_int_en    = int_en;
        next_int_stat  = int_stat;
        fire           = '0;
        late           = '0;
        next_rdata     = ZERO32;

        // Timestamp units count pin rising edges while enabled and the pin is an input.
        for (int u = 0; u < NUM_TS; u++) begin
            if (ts_en[u] && !ts_rst[u] && dir && pin_rise) begin
                next_capture_ready_flag[u] = 1'b1;
                if (ts_cnt[u] == CNT_MAX) begin
                    next_ts_ovf[u] = 1'b1;
                end else begin
                    next_ts_cnt[u] = ts_cnt[u] + 1'b1;
                end
                if (ts_int_en[u]) begin
                    next_int_stat[I_TS0 + u] = 1'b1;
                end
            end
        end

        // Trigger units fire once the system time reaches the target while tr_lvl is clear, or at once when B_NOW is set.
        for (int u = 0; u < NUM_TRIG; u++) begin
            late[u] = time_reached(SYS_TIME_I, tgt_s[u], tgt_ns[u]);
            if (tr_en[u] && !tr_rst[u] && !tr_err[u]) begin
                if (late[u] && !tr_lvl[u] && !tr_cfg[u][B_NOW]) begin
                    fire[u] = 1'b1;
                end else if (tr_cfg[u][B_NOW]) begin
                    fire[u] = 1'b1;
                end
            end
            if (fire[u]) begin
                next_tr_en[u]  = 1'b0;
                next_tr_lvl[u] = tr_cfg[u][B_LEVEL];
                if (tr_cfg[u][B_NOTIFY]) begin
                    next_int_stat[I_DONE0 + u] = 1'b1;
                end
            end
        end

        // Register writes; indexed fields go to the unit picked at access time.
        if (REQ_I.wr) begin
            unique case (REQ_I.addr)
                OFS_CTRL: begin
                    next_out_sel           = REQ_I.wdata[B_OUT_SEL];
                    next_dir               = REQ_I.wdata[B_DIR];
                    next_ts_int_en[ts_idx] = REQ_I.wdata[B_TS_INT_EN];
                    next_tr_rst[trig_idx]  = REQ_I.wdata[B_TRIG_RST];
                    next_ts_rst[ts_idx]    = REQ_I.wdata[B_TS_RST];
                    if (REQ_I.wdata[B_TRIG_RST]) begin
                        next_tr_en[trig_idx]  = 1'b0;
                        next_tr_err[trig_idx] = 1'b0;
                        next_tr_lvl[trig_idx] = 1'b0;
                        next_tr_cfg[trig_idx] = '0;
                    end else begin
                        next_tr_en[trig_idx] = REQ_I.wdata[B_TRIG_EN];
                        if (!REQ_I.wdata[B_TRIG_EN]) begin
                            next_tr_err[trig_idx] = 1'b0;
                            next_int_stat[I_ERR0 + trig_idx] = 1'b0;
                        end
                    end
                    if (REQ_I.wdata[B_TS_RST]) begin
                        next_ts_en[ts_idx]     = 1'b0;
                        next_ts_int_en[ts_idx] = 1'b0;
                        next_capture_ready_flag[ts_idx]    = 1'b0;
                        next_ts_ovf[ts_idx]    = 1'b0;
                        next_ts_cnt[ts_idx]    = '0;
                    end else if (REQ_I.wdata[B_TS_EN]) begin
                        next_ts_en[ts_idx]  = 1'b1;
                        next_ts_cnt[ts_idx] = '0;
                    end else begin
                        next_ts_en[ts_idx]  = 1'b0;
                        next_capture_ready_flag[ts_idx] = 1'b0;
                        next_ts_ovf[ts_idx] = 1'b0;
                    end
                end
                OFS_TGT_NS:   next_tgt_ns[trig_idx] = REQ_I.wdata[NS_W-1:0];
                OFS_TGT_S:    next_tgt_s[trig_idx]  = REQ_I.wdata;
                OFS_INDEX: begin
                    if (REQ_I.wdata[1:0] <= TRIG_IDX_MAX) begin
                        next_trig_idx = REQ_I.wdata[1:0];
                    end
                    next_ts_idx = REQ_I.wdata[B_TS_IDX];
                end
                OFS_TRIG_CFG: next_tr_cfg[trig_idx] = REQ_I.wdata[2:0];
                OFS_INT_CLR:  next_int_stat = next_int_stat & ~(REQ_I.wdata[NUM_IRQ-1:0] & ~(
                                  next_int_stat & ~int_stat));
                OFS_INT_EN:   next_int_en   = REQ_I.wdata[NUM_IRQ-1:0];
                default: ;
            endcase
        end

        // A late target with no immediate trigger is an error.
        for (int u = 0; u < NUM_TRIG; u++) begin
            if (next_tr_en[u] && !tr_en[u] && late[u] && !next_tr_cfg[u][B_NOW] &&
                !(wr_ctrl && REQ_I.wdata[B_TRIG_RST])) begin
                next_tr_err[u] = 1'b1;
                if (next_tr_cfg[u][B_NOTIFY]) begin
                    next_int_stat[I_ERR0 + u] = 1'b1;
                end
            end
        end

        if (REQ_I.rd) begin
            unique case (REQ_I.addr)
                OFS_CTRL: begin
                    next_rdata[B_OUT_SEL]   = out_sel;
                    next_rdata[B_PIN_IN]    = pin_s2;
                    next_rdata[B_DIR]       = dir;
                    next_rdata[B_TS_INT_EN] = ts_int_en[ts_idx];
                    next_rdata[B_TRIG_ACT]  = tr_en[trig_idx] & ~tr_err[trig_idx];
                    next_rdata[B_TRIG_EN]   = tr_en[trig_idx];
                    next_rdata[B_TRIG_RST]  = tr_rst[trig_idx];
                    next_rdata[B_TS_EN]     = ts_en[ts_idx];
                    next_rdata[B_TS_RST]    = ts_rst[ts_idx];
                end
                OFS_TGT_NS:   next_rdata[NS_W-1:0] = tgt_ns[trig_idx];
                OFS_TGT_S:    next_rdata = tgt_s[trig_idx];
                OFS_INDEX: begin
                    next_rdata[1:0]      = trig_idx;
                    next_rdata[B_TS_IDX] = ts_idx;
                end
                OFS_TRIG_CFG: next_rdata[2:0] = tr_cfg[trig_idx];
                OFS_INT_STAT: next_rdata[NUM_IRQ-1:0] = int_stat;
                OFS_INT_EN:   next_rdata[NUM_IRQ-1:0] = int_en;
                default: ;
            endcase
        end
        comb_out = |(next_tr_lvl | fire);
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            trig_idx  <= '0;
            ts_idx    <= 1'b0;
            out_sel   <= 1'b0;
            dir       <= 1'b0;
            ts_int_en <= '0;
            ts_en     <= '0;
            ts_rst    <= '0;
            capture_ready_flag    <= '0;
            ts_ovf    <= '0;
            tr_en     <= '0;
            tr_rst    <= '0;
            tr_err    <= '0;
            tr_lvl    <= '0;
            int_stat  <= '0;
            int_en    <= '0;
            RDATA_O   <= ZERO32;
            for (int u = 0; u < NUM_TS; u++) begin
                ts_cnt[u] <= '0;
            end
            for (int u = 0; u < NUM_TRIG; u++) begin
                tr_cfg[u] <= '0;
                tgt_ns[u] <= '0;
                tgt_s[u]  <= ZERO32;
            end
        end else begin
            trig_idx  <= next_trig_idx;
            ts_idx    <= next_ts_idx;
            out_sel   <= next_out_sel;
            dir       <= next_dir;
            ts_int_en <= next_ts_int_en;
            ts_en     <= next_ts_en;
            ts_rst    <= next_ts_rst;
            capture_ready_flag    <= next_capture_ready_flag;
            ts_ovf    <= next_ts_ovf;
            ts_cnt    <= next_ts_cnt;
            tr_en     <= next_tr_en;
            tr_rst    <= next_tr_rst;
            tr_err    <= next_tr_err;
            tr_lvl    <= next_tr_lvl;
            tr_cfg    <= next_tr_cfg;
            tgt_ns    <= next_tgt_ns;
            tgt_s     <= next_tgt_s;
            int_stat  <= next_int_stat;
            int_en    <= next_int_en;
            RDATA_O   <= next_rdata;
        end
    end

    // Pin drivers: the combinational path is precomputed one cycle ahead so
    // that every output still comes from a flip-flop.
    logic comb_q;
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            comb_q   <= 1'b0;
            PIN_O    <= 1'b0;
            PIN_OE_O <= 1'b0;
            IRQ_O    <= 1'b0;
        end else begin
            comb_q   <= comb_out;
            PIN_O    <= next_out_sel ? comb_out : comb_q;
            PIN_OE_O <= ~next_dir;
            IRQ_O    <= |(next_int_stat & next_int_en);
        end
    end

    AST_OE_FOLLOWS_DIR:
    assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        $past(NRST_I) |-> (PIN_OE_O == ~dir))
    else $error("pin enable does not follow direction");

    AST_TRIG_SELF_CLEAR:
    assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (fire[trig_idx] && !REQ_I.wr) |=> !tr_en[$past(trig_idx)])
    else $error("trigger enable did not self clear");

    AST_TRIG_RESET:
    assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (wr_ctrl && REQ_I.wdata[B_TRIG_RST]) |=> (!tr_en[$past(trig_idx)] && !tr_lvl[$past(trig_idx)]))
    else $error("trigger soft reset did not idle the unit");

    AST_TS_ENABLE_CLEARS:
    assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (wr_ctrl && REQ_I.wdata[B_TS_EN] && !REQ_I.wdata[B_TS_RST]) |=>
            (ts_cnt[$past(ts_idx)] == '0) && ts_en[$past(ts_idx)])
    else $error("timestamp enable did not zero the count");

    AST_TS_DISABLE_FLAGS:
    assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (wr_ctrl && !REQ_I.wdata[B_TS_EN]) |=> (!capture_ready_flag[$past(ts_idx)] && !ts_ovf[$past(ts_idx)]))
    else $error("timestamp disable left flags set");

    AST_NS_RESERVED:
    assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        $past(REQ_I.rd && REQ_I.addr == OFS_TGT_NS) |-> RDATA_O[31:NS_W] == 2'h0)
    else $error("reserved nanosecond bits read non-zero");

    AST_ERR_CLEAR:
    assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (wr_ctrl && !REQ_I.wdata[B_TRIG_EN]) |=> !tr_err[$past(trig_idx)])
    else $error("trigger error not cleared by disable");

    AST_PIN_READBACK:
    assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (REQ_I.rd && REQ_I.addr == OFS_CTRL) |=> RDATA_O[B_PIN_IN] == $past(pin_s2))
    else $error("pin monitor bit wrong");

    AST_IRQ_LEVEL:
    assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        IRQ_O == |(int_stat & int_en))
    else $error("interrupt output disagrees with status");

    AST_NO_EARLY_FIRE:
    assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (fire[trig_idx] && !tr_cfg[trig_idx][B_NOW]) |-> late[trig_idx])
    else $error("trigger fired before its target time");

    AST_ERR_STATUS_CLEAR:
    assert property (@(posedge CORE_CLK_I) disable iff (!NRST_I)
        (wr_ctrl && !REQ_I.wdata[B_TRIG_EN]) |=> !int_stat[I_ERR0 + $past(trig_idx)])
    else $error("trigger error status not cleared by disable");
endmodule

// file: ptstc_top_tb.sv
/*
 * Self-checking bench for the trigger and timestamp control block.
 * Assumes read data stand one cycle after the read strobe and a 50 MHz clock.
 */
module ptstc_top_tb
    import ptstc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] ALL   = 32'hFFFF_FFFF;
    localparam logic [31:0] M_SEL = 32'h1 << B_OUT_SEL;
    localparam logic [31:0] M_PIN = 32'h1 << B_PIN_IN;
    localparam logic [31:0] M_DIR = 32'h1 << B_DIR;
    localparam logic [31:0] M_TIE = 32'h1 << B_TS_INT_EN;
    localparam logic [31:0] M_ACT = 32'h1 << B_TRIG_ACT;
    localparam logic [31:0] M_TEN = 32'h1 << B_TRIG_EN;
    localparam logic [31:0] M_TRS = 32'h1 << B_TRIG_RST;
    localparam logic [31:0] M_SEN = 32'h1 << B_TS_EN;
    localparam logic [31:0] M_SRS = 32'h1 << B_TS_RST;

    logic              clk;
    logic              nrst;
    logic              pin_i;
    logic              pin_o;
    logic              pin_oe;
    logic              irq;
    logic [DATA_W-1:0] rdata;
    ptstc_req_type     req;
    ptstc_time_type    sys_time;
    int                fails;
    int                samples_checked;
    int                lat[2];

    ptstc_top dut (
        .CORE_CLK_I (clk),
        .NRST_I     (nrst),
        .REQ_I      (req),
        .RDATA_O    (rdata),
        .SYS_TIME_I (sys_time),
        .PIN_I      (pin_i),
        .PIN_O      (pin_o),
        .PIN_OE_O   (pin_oe),
        .IRQ_O      (irq)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr    <= 1'b0;
    endtask

    // Read data are sampled just after the edge that takes the strobe.
    task automatic rd_chk(input string what, input logic [11:0] a,
                          input logic [31:0] msk, input logic [31:0] exp);
        @(posedge clk);
        req.rd   <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd   <= 1'b0;
        #1;
        check(what, rdata & msk, exp);
    endtask

    task automatic idx(input int t, input int s);
        wr(OFS_INDEX, (32'(s) << B_TS_IDX) | 32'(t));
    endtask

    // Counts edges until the pin output goes high, giving up after 20.
    task automatic wait_pin(output int n);
        n = 0;
        while (pin_o !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("pin pulse seen", 32'(n < 20), 32'h1);
    endtask

    task automatic fire(input logic sel, output int n);
        idx(0, 0);
        wr(OFS_TRIG_CFG, 32'h1 << B_NOTIFY);
        wr(OFS_TGT_S, 32'h10);
        wr(OFS_TGT_NS, 32'h100);
        wr(OFS_CTRL, (sel ? M_SEL : ZERO32) | M_TEN);
        rd_chk("armed", OFS_CTRL, M_ACT | M_TEN, M_ACT | M_TEN);
        check("no early fire", 32'(pin_o), 32'h0);
        @(posedge clk);
        sys_time.ns <= 30'h100;
        wait_pin(n);
        cyc(3);
        rd_chk("self clear", OFS_CTRL, M_ACT | M_TEN, ZERO32);
        @(posedge clk);
        sys_time.ns <= 30'h0;
    endtask

    task automatic pulse;
        @(posedge clk);
        pin_i <= 1'b1;
        cyc(6);
        pin_i <= 1'b0;
        cyc(6);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        give_verdict();
    end

    initial begin
        nrst     = 1'b0;
        pin_i    = 1'b0;
        req      = '0;
        sys_time = '{sec: 32'h10, ns: 30'h0};
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        cyc(2);
        rd_chk("ctrl reset", OFS_CTRL, ALL, ZERO32);
        check("oe reset", 32'(pin_oe), 32'h1);
        rd_chk("ns reset", OFS_TGT_NS, ALL, ZERO32);
        rd_chk("s reset", OFS_TGT_S, ALL, ZERO32);
        rd_chk("unmapped", 12'h7FC, ALL, ZERO32);
        $display("test reset done");

        for (int t = 0; t < NUM_TRIG; t++) begin
            idx(t, 0);
            wr(OFS_TGT_NS, 32'hFFFF_FFF0 | 32'(t));
            wr(OFS_TGT_S, 32'hA5A5_0000 | 32'(t));
        end
        for (int t = 0; t < NUM_TRIG; t++) begin
            idx(t, 0);
            rd_chk("target ns", OFS_TGT_NS, ALL, 32'h3FFF_FFF0 | 32'(t));
            rd_chk("target s", OFS_TGT_S, ALL, 32'hA5A5_0000 | 32'(t));
        end
        idx(3, 0);
        rd_chk("bad index kept", OFS_TGT_S, ALL, 32'hA5A5_0002);
        $display("test indexed targets done");

        @(posedge clk);
        pin_i <= 1'b1;
        cyc(4);
        rd_chk("pin level high", OFS_CTRL, M_PIN, M_PIN);
        @(posedge clk);
        pin_i <= 1'b0;
        cyc(4);
        rd_chk("pin level low", OFS_CTRL, M_PIN, ZERO32);
        wr(OFS_CTRL, M_DIR);
        cyc(2);
        check("oe input", 32'(pin_oe), 32'h0);
        wr(OFS_CTRL, ZERO32);
        cyc(2);
        check("oe output", 32'(pin_oe), 32'h1);
        $display("test pin done");

        fire(1'b1, lat[1]);
        wr(OFS_INT_EN, 32'h1 << I_DONE0);
        cyc(2);
        check("irq raised", 32'(irq), 32'h1);
        rd_chk("done status", OFS_INT_STAT, 32'h1, 32'h1);
        wr(OFS_INT_CLR, 32'h1 << I_DONE0);
        cyc(2);
        check("irq cleared", 32'(irq), 32'h0);
        wr(OFS_INT_EN, ZERO32);
        fire(1'b0, lat[0]);
        check("irq masked", 32'(irq), 32'h0);
        rd_chk("done while masked", OFS_INT_STAT, 32'h1, 32'h1);
        check("flop adds a cycle", 32'(lat[0] - lat[1]), 32'h1);
        wr(OFS_INT_CLR, 32'hFF);
        $display("test trigger fire done");

        @(posedge clk);
        sys_time.ns <= 30'h200;
        wr(OFS_CTRL, M_TEN);
        cyc(3);
        rd_chk("late target error", OFS_INT_STAT, 32'h1 << I_ERR0, 32'h1 << I_ERR0);
        rd_chk("late not active", OFS_CTRL, M_ACT, ZERO32);
        wr(OFS_CTRL, ZERO32);
        cyc(2);
        rd_chk("error cleared", OFS_INT_STAT, 32'h1 << I_ERR0, ZERO32);
        wr(OFS_TRIG_CFG, (32'h1 << B_NOW) | (32'h1 << B_NOTIFY));
        wr(OFS_CTRL, M_TEN);
        wait_pin(lat[0]);
        wr(OFS_INT_CLR, 32'hFF);
        $display("test error and trigger now done");

        wr(OFS_TRIG_CFG, (32'h1 << B_NOW) | (32'h1 << B_LEVEL));
        wr(OFS_CTRL, M_TEN);
        wait_pin(lat[0]);
        cyc(4);
        check("level holds pin", 32'(pin_o), 32'h1);
        wr(OFS_CTRL, M_TRS);
        cyc(3);
        check("soft reset drops pin", 32'(pin_o), 32'h0);
        wr(OFS_CTRL, ZERO32);
        wr(OFS_TRIG_CFG, ZERO32);
        wr(OFS_TGT_S, 32'h20);
        wr(OFS_CTRL, M_TEN);
        rd_chk("long wait active", OFS_CTRL, M_ACT | M_TEN, M_ACT | M_TEN);
        wr(OFS_CTRL, M_TRS);
        cyc(2);
        rd_chk("soft reset idles", OFS_CTRL, M_TRS | M_ACT | M_TEN, M_TRS);
        wr(OFS_CTRL, ZERO32);
        wr(OFS_CTRL, M_TEN);
        rd_chk("ready again", OFS_CTRL, M_ACT | M_TEN, M_ACT | M_TEN);
        wr(OFS_CTRL, ZERO32);
        $display("test trigger soft reset done");

        wr(OFS_INT_EN, 32'h3 << I_TS0);
        idx(0, 1);
        wr(OFS_CTRL, M_DIR | M_SEN);
        pulse();
        check("ts irq masked", 32'(irq), 32'h0);
        wr(OFS_INT_CLR, 32'hFF);
        idx(0, 0);
        wr(OFS_CTRL, M_DIR | M_TIE | M_SEN);
        pulse();
        check("ts irq", 32'(irq), 32'h1);
        rd_chk("ts status", OFS_INT_STAT, 32'h1 << I_TS0, 32'h1 << I_TS0);
        wr(OFS_INT_CLR, 32'hFF);
        cyc(2);
        check("ts irq cleared", 32'(irq), 32'h0);
        wr(OFS_CTRL, M_DIR | M_TIE | M_SEN | M_SRS);
        rd_chk("ts reset stored", OFS_CTRL, M_SRS | M_TIE | M_SEN, M_SRS);
        pulse();
        check("ts reset idles", 32'(irq), 32'h0);
        wr(OFS_CTRL, M_TIE | M_SEN);
        pulse();
        check("output mode ignores pin", 32'(irq), 32'h0);
        $display("test timestamp done");
        give_verdict();
    end
endmodule
